// file: shared/sfra_pkg.sv
// Purpose: Shared constants for the serial flash register access ends
// Assumes: 200 MHz block clock on both ends
// Notes:   Write-time counts derive from the nanosecond figures below; SCK_HALF_CYC is a fixed cycle count
package sfra_pkg;
  typedef enum logic [1:0]
  {
    SFRA_EXT  = 2'b00,
    SFRA_DUAL = 2'b01,
    SFRA_QUAD = 2'b10
  } sfra_proto_type;

  localparam logic [7:0] OP_WREN    = 8'h06;
  localparam logic [7:0] OP_RD_SR   = 8'h05;
  localparam logic [7:0] OP_RD_FSR  = 8'h70;
  localparam logic [7:0] OP_RD_NVCR = 8'hb5;
  localparam logic [7:0] OP_RD_VCR  = 8'h85;
  localparam logic [7:0] OP_RD_EVCR = 8'h65;
  localparam logic [7:0] OP_WR_SR   = 8'h01;
  localparam logic [7:0] OP_WR_NVCR = 8'hb1;
  localparam logic [7:0] OP_WR_VCR  = 8'h81;
  localparam logic [7:0] OP_WR_EVCR = 8'h61;

  // Status bit positions
  localparam int SR_WIP_BIT   = 0;
  localparam int SR_WEL_BIT   = 1;
  localparam int SR_SRWD_BIT  = 7;
  localparam int FSR_RDY_BIT  = 7;
  localparam int FSR_PROT_BIT = 1;

  localparam logic [7:0]  SR_RESET     = 8'h00;
  localparam logic [7:0]  FSR_RESET    = 8'h80;
  localparam logic [15:0] NVCR_RESET   = 16'hffff;
  localparam logic [7:0]  VCR_RESET    = 8'hfb;
  localparam logic [7:0]  EVCR_RESET   = 8'hdf;
  localparam logic [15:0] NVCR_RSVD    = 16'h0010;
  localparam logic [7:0]  VCR_RSVD     = 8'h04;
  localparam logic [7:0]  EVCR_RSVD    = 8'h10;

  localparam int CLK_MHZ                 = 200;
  localparam int STATUS_WRITE_TIME_NS    = 1000;
  localparam int NV_CONFIG_WRITE_TIME_NS = 2000;
  localparam int STATUS_WRITE_CYC        = (STATUS_WRITE_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int NV_CONFIG_WRITE_CYC     = (NV_CONFIG_WRITE_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int SCK_HALF_CYC            = 16;
endpackage

// file: shared/sfra_if.sv
// Purpose: Serial link between host controller and flash register end
// Assumes: Both ends drive lanes with explicit enables
// Notes:   Undriven lanes resolve high, as with pull-ups
`timescale 1ns/10ps
`default_nettype none
interface sfra_if;
  logic       cs_n;
  logic       sck;
  logic       wp_n;
  logic [3:0] h_dq;
  logic [3:0] h_dq_oe;
  logic [3:0] d_dq;
  logic [3:0] d_dq_oe;
  logic [3:0] dq;

  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      dq[i] = h_dq_oe[i] ? h_dq[i] : (d_dq_oe[i] ? d_dq[i] : 1'b1);
    end
  end

  modport host (output cs_n, sck, wp_n, h_dq, h_dq_oe, input dq);
  modport dev  (input cs_n, sck, wp_n, dq, output d_dq, d_dq_oe);
endinterface
`default_nettype wire

// file: logic/sfra_device.sv
// Purpose: Flash end answering register read and write commands
// Assumes: Link pins are asynchronous and sampled through two flops
// Notes:   Data in on sck rise, out on fall
`timescale 1ns/10ps
`default_nettype none
module sfra_device #(
  parameter int SR_CYC  = sfra_pkg::STATUS_WRITE_CYC,
  parameter int NV_CYC  = sfra_pkg::NV_CONFIG_WRITE_CYC
) (
  input  wire logic                     ref_clk_i,
  input  wire logic                     resetn_i,
  sfra_if.dev                           link,
  input  wire sfra_pkg::sfra_proto_type mode_i,
  output logic [7:0]                    sr_o,
  output logic [7:0]                    fsr_o,
  output logic [15:0]                   nvcr_o,
  output logic [7:0]                    vcr_o,
  output logic [7:0]                    evcr_o
);
  typedef enum logic [1:0]
  {
    SFRA_PH_CMD = 2'b00,
    SFRA_PH_IN  = 2'b01,
    SFRA_PH_OUT = 2'b10
  } sfra_phase_type;

  logic [6:0]     sync1_reg;
  logic [6:0]     sync2_reg;
  logic           sck_d_reg;
  logic           cs_d_reg;
  sfra_phase_type phase_reg;
  logic [5:0]     bitcnt_reg;
  logic [23:0]    in_reg;
  logic [7:0]     op_reg;
  logic [7:0]     osh_reg;
  logic [2:0]     obit_reg;
  logic [1:0]     obyte_reg;
  logic [3:0]     dq_reg;
  logic [3:0]     dq_oe_reg;
  logic [5:0]     sr_hi_reg;
  logic           wel_reg;
  logic           wip_reg;
  logic           prot_reg;
  logic [15:0]    nvcr_reg;
  logic [7:0]     vcr_reg;
  logic [7:0]     evcr_reg;
  logic [15:0]    timer_reg;
  logic           pend_nv_reg;
  logic [15:0]    pend_reg;

  logic        sck_s, cs_s, wp_s;
  logic [3:0]  dq_s;
  logic        sck_rise, sck_fall, cs_rise;
  logic [2:0]  w;
  logic [23:0] in_next;
  logic [5:0]  bitcnt_next;
  logic [7:0]  sr_live, fsr_live, out_byte, cur;
  logic [15:0] nv_rd;

  assign sck_s = sync2_reg[6];
  assign cs_s  = sync2_reg[5];
  assign wp_s  = sync2_reg[4];
  assign dq_s  = sync2_reg[3:0];
  assign sck_rise = sck_s & ~sck_d_reg;
  assign sck_fall = ~sck_s & sck_d_reg;
  assign cs_rise  = cs_s & ~cs_d_reg;

  assign sr_live  = {sr_hi_reg, wel_reg, wip_reg};
  assign fsr_live = {~wip_reg, 5'h00, prot_reg, 1'b0};
  assign nv_rd    = nvcr_reg | sfra_pkg::NVCR_RSVD;

  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      // Serial clock idles low, so its stages start low to avoid a false fall
      sync1_reg <= 7'h3f;
      sync2_reg <= 7'h3f;
      sck_d_reg <= 1'b0;
      cs_d_reg  <= 1'b1;
    end
    else
    begin
      sync1_reg <= {link.sck, link.cs_n, link.wp_n, link.dq};
      sync2_reg <= sync1_reg;
      sck_d_reg <= sck_s;
      cs_d_reg  <= cs_s;
    end
  end

  // Lane width and input shift
  always_comb
  begin
    unique case (mode_i)
      sfra_pkg::SFRA_DUAL:
      begin
        w = 3'd2;
        in_next = {in_reg[21:0], dq_s[1:0]};
      end
      sfra_pkg::SFRA_QUAD:
      begin
        w = 3'd4;
        in_next = {in_reg[19:0], dq_s};
      end
      default:
      begin
        w = 3'd1;
        in_next = {in_reg[22:0], dq_s[0]};
      end
    endcase
    bitcnt_next = (bitcnt_reg < 6'd56) ? bitcnt_reg + {3'b000, w} : bitcnt_reg;
  end

  always_comb
  begin
    unique case (op_reg)
      sfra_pkg::OP_RD_SR:   out_byte = sr_live;
      sfra_pkg::OP_RD_FSR:  out_byte = fsr_live;
      sfra_pkg::OP_RD_NVCR: out_byte = (obyte_reg == 2'd0) ? nv_rd[7:0] :
                                       (obyte_reg == 2'd1) ? nv_rd[15:8] : 8'h00;
      sfra_pkg::OP_RD_VCR:  out_byte = vcr_reg;
      sfra_pkg::OP_RD_EVCR: out_byte = evcr_reg;
      default:              out_byte = 8'h00;
    endcase
    cur = (obit_reg == 3'd0) ? out_byte : osh_reg;
  end

  // Command framing, input capture and read output
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      phase_reg  <= SFRA_PH_CMD;
      bitcnt_reg <= 6'h00;
      in_reg     <= 24'h000000;
      op_reg     <= 8'h00;
      osh_reg    <= 8'h00;
      obit_reg   <= 3'h0;
      obyte_reg  <= 2'h0;
      dq_reg     <= 4'h0;
      dq_oe_reg  <= 4'h0;
    end
    else if (cs_s)
    begin
      phase_reg  <= SFRA_PH_CMD;
      bitcnt_reg <= 6'h00;
      obit_reg   <= 3'h0;
      obyte_reg  <= 2'h0;
      dq_oe_reg  <= 4'h0;
    end
    else if (sck_rise && phase_reg != SFRA_PH_OUT)
    begin
      in_reg     <= in_next;
      bitcnt_reg <= bitcnt_next;
      if (phase_reg == SFRA_PH_CMD && bitcnt_next == 6'd8)
      begin
        op_reg <= in_next[7:0];
        unique case (in_next[7:0])
          sfra_pkg::OP_RD_SR, sfra_pkg::OP_RD_FSR, sfra_pkg::OP_RD_NVCR,
          sfra_pkg::OP_RD_VCR, sfra_pkg::OP_RD_EVCR: phase_reg <= SFRA_PH_OUT;
          default:                                    phase_reg <= SFRA_PH_IN;
        endcase
      end
    end
    else if (sck_fall && phase_reg == SFRA_PH_OUT)
    begin
      unique case (mode_i)
        sfra_pkg::SFRA_DUAL:
        begin
          dq_reg    <= {2'b00, cur[7:6]};
          dq_oe_reg <= 4'b0011;
        end
        sfra_pkg::SFRA_QUAD:
        begin
          dq_reg    <= cur[7:4];
          dq_oe_reg <= 4'b1111;
        end
        default:
        begin
          dq_reg    <= {2'b00, cur[7], 1'b0};
          dq_oe_reg <= 4'b0010;
        end
      endcase
      osh_reg  <= cur << w;
      obit_reg <= obit_reg + w;
      if (obit_reg + w == 3'd0 && obyte_reg != 2'd2)
      begin
        obyte_reg <= obyte_reg + 2'd1;
      end
    end
  end

  // Register state, write acceptance and self-timed writes
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      sr_hi_reg   <= sfra_pkg::SR_RESET[7:2];
      wel_reg     <= 1'b0;
      wip_reg     <= 1'b0;
      prot_reg    <= sfra_pkg::FSR_RESET[sfra_pkg::FSR_PROT_BIT];
      nvcr_reg    <= sfra_pkg::NVCR_RESET;
      vcr_reg     <= sfra_pkg::VCR_RESET;
      evcr_reg    <= sfra_pkg::EVCR_RESET;
      timer_reg   <= 16'h0000;
      pend_nv_reg <= 1'b0;
      pend_reg    <= 16'h0000;
    end
    else if (wip_reg)
    begin
      if (timer_reg == 16'h0001)
      begin
        if (pend_nv_reg)
        begin
          nvcr_reg <= pend_reg;
        end
        else
        begin
          sr_hi_reg <= pend_reg[7:2];
        end
        wip_reg <= 1'b0;
        wel_reg <= 1'b0;
      end
      timer_reg <= timer_reg - 16'h0001;
    end
    else if (cs_rise && phase_reg == SFRA_PH_IN)
    begin
      // Any count off the byte boundary falls through untouched
      if (op_reg == sfra_pkg::OP_WREN && bitcnt_reg == 6'd8)
      begin
        wel_reg <= 1'b1;
      end
      else if (wel_reg)
      begin
        if (op_reg == sfra_pkg::OP_WR_SR && bitcnt_reg == 6'd16)
        begin
          if (sr_hi_reg[sfra_pkg::SR_SRWD_BIT - 2] && !wp_s)
          begin
            prot_reg <= 1'b1;
          end
          else
          begin
            pend_reg    <= {8'h00, in_reg[7:0]};
            pend_nv_reg <= 1'b0;
            timer_reg   <= SR_CYC[15:0];
            wip_reg     <= 1'b1;
          end
        end
        if (op_reg == sfra_pkg::OP_WR_NVCR && bitcnt_reg == 6'd24)
        begin
          pend_reg    <= {in_reg[7:0], in_reg[15:8]};
          pend_nv_reg <= 1'b1;
          timer_reg   <= NV_CYC[15:0];
          wip_reg     <= 1'b1;
        end
        if (op_reg == sfra_pkg::OP_WR_VCR && bitcnt_reg == 6'd16)
        begin
          vcr_reg <= (in_reg[7:0] & ~sfra_pkg::VCR_RSVD) | (vcr_reg & sfra_pkg::VCR_RSVD);
          wel_reg <= 1'b0;
        end
        if (op_reg == sfra_pkg::OP_WR_EVCR && bitcnt_reg == 6'd16)
        begin
          evcr_reg <= (in_reg[7:0] & ~sfra_pkg::EVCR_RSVD) | (evcr_reg & sfra_pkg::EVCR_RSVD);
          wel_reg  <= 1'b0;
        end
      end
    end
  end

  assign link.d_dq    = dq_reg;
  assign link.d_dq_oe = dq_oe_reg;

  // User-side copies, each from a flop
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      sr_o   <= sfra_pkg::SR_RESET;
      fsr_o  <= sfra_pkg::FSR_RESET;
      nvcr_o <= sfra_pkg::NVCR_RESET;
      vcr_o  <= sfra_pkg::VCR_RESET;
      evcr_o <= sfra_pkg::EVCR_RESET;
    end
    else
    begin
      sr_o   <= sr_live;
      fsr_o  <= fsr_live;
      nvcr_o <= nv_rd;
      vcr_o  <= vcr_reg;
      evcr_o <= evcr_reg;
    end
  end
endmodule
`default_nettype wire

// file: logic/sfra_host.sv
// Purpose: Host controller framing one command per start request
// Assumes: Serial clock derived here by a divider of the block clock
// Notes:   Drives lanes while sck is low; samples just before each rise
`timescale 1ns/10ps
`default_nettype none
module sfra_host #(
  parameter int HALF = sfra_pkg::SCK_HALF_CYC
) (
  input  wire logic                     ref_clk_i,
  input  wire logic                     resetn_i,
  sfra_if.host                          link,
  input  wire logic                     start_i,
  input  wire sfra_pkg::sfra_proto_type mode_i,
  input  wire logic [7:0]               op_i,
  input  wire logic [15:0]              wdata_i,
  input  wire logic [1:0]               tx_bytes_i,
  input  wire logic [2:0]               rx_bytes_i,
  input  wire logic                     wp_n_i,
  output logic                          busy_o,
  output logic                          done_o,
  output logic [31:0]                   rdata_o
);
  typedef enum logic [2:0]
  {
    SFRA_H_IDLE = 3'b000,
    SFRA_H_LEAD = 3'b001,
    SFRA_H_LOW  = 3'b010,
    SFRA_H_HIGH = 3'b011,
    SFRA_H_TAIL = 3'b100,
    SFRA_H_GAP  = 3'b101
  } sfra_hstate_type;

  sfra_hstate_type st_reg;
  logic [15:0]     ph_reg;
  logic [2:0]      w_reg;
  logic [31:0]     tx_reg;
  logic [31:0]     rx_reg;
  logic [5:0]      txbits_reg;
  logic [5:0]      rxbits_reg;
  logic            cs_n_reg;
  logic            sck_reg;
  logic [3:0]      dq_reg;
  logic [3:0]      dq_oe_reg;
  logic [3:0]      dq1_reg;
  logic [3:0]      dq2_reg;
  logic            ph_end;
  logic            wp_n_reg;

  assign ph_end = (ph_reg == HALF[15:0] - 16'h0001);

  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      dq1_reg <= 4'hf;
      dq2_reg <= 4'hf;
    end
    else
    begin
      dq1_reg <= link.dq;
      dq2_reg <= dq1_reg;
    end
  end

  // Registered so every link output leaves from a flop
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      wp_n_reg <= 1'b1;
    end
    else
    begin
      wp_n_reg <= wp_n_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      st_reg     <= SFRA_H_IDLE;
      ph_reg     <= 16'h0000;
      w_reg      <= 3'd1;
      tx_reg     <= 32'h00000000;
      rx_reg     <= 32'h00000000;
      txbits_reg <= 6'h00;
      rxbits_reg <= 6'h00;
      cs_n_reg   <= 1'b1;
      sck_reg    <= 1'b0;
      dq_reg     <= 4'h0;
      dq_oe_reg  <= 4'h0;
      busy_o     <= 1'b0;
      done_o     <= 1'b0;
      rdata_o    <= 32'h00000000;
    end
    else
    begin
      done_o <= 1'b0;
      ph_reg <= ph_end ? 16'h0000 : ph_reg + 16'h0001;
      unique case (st_reg)
        SFRA_H_IDLE:
        begin
          ph_reg <= 16'h0000;
          if (start_i)
          begin
            // Nonvolatile data goes low byte first
            tx_reg     <= {op_i, wdata_i[7:0], wdata_i[15:8], 8'h00};
            txbits_reg <= {1'b0, tx_bytes_i, 3'b000} + 6'd8;
            rxbits_reg <= {rx_bytes_i, 3'b000};
            w_reg      <= (mode_i == sfra_pkg::SFRA_QUAD) ? 3'd4 :
                          (mode_i == sfra_pkg::SFRA_DUAL) ? 3'd2 : 3'd1;
            rx_reg     <= 32'h00000000;
            cs_n_reg   <= 1'b0;
            busy_o     <= 1'b1;
            st_reg     <= SFRA_H_LEAD;
          end
        end
        SFRA_H_LEAD:
        begin
          if (ph_end)
          begin
            st_reg <= SFRA_H_LOW;
          end
        end
        SFRA_H_LOW:
        begin
          if (ph_reg == 16'h0000)
          begin
            if (txbits_reg != 6'h00)
            begin
              unique case (w_reg)
                3'd4:    dq_reg <= tx_reg[31:28];
                3'd2:    dq_reg <= {2'b00, tx_reg[31:30]};
                default: dq_reg <= {3'b000, tx_reg[31]};
              endcase
              dq_oe_reg <= (w_reg == 3'd4) ? 4'b1111 : (w_reg == 3'd2) ? 4'b0011 : 4'b0001;
            end
            else
            begin
              dq_oe_reg <= 4'h0;
            end
          end
          if (ph_end)
          begin
            sck_reg <= 1'b1;
            st_reg  <= SFRA_H_HIGH;
            if (txbits_reg != 6'h00)
            begin
              tx_reg     <= tx_reg << w_reg;
              txbits_reg <= txbits_reg - {3'b000, w_reg};
            end
            else
            begin
              unique case (w_reg)
                3'd4:    rx_reg <= {rx_reg[27:0], dq2_reg};
                3'd2:    rx_reg <= {rx_reg[29:0], dq2_reg[1:0]};
                default: rx_reg <= {rx_reg[30:0], dq2_reg[1]};
              endcase
              rxbits_reg <= rxbits_reg - {3'b000, w_reg};
            end
          end
        end
        SFRA_H_HIGH:
        begin
          if (ph_end)
          begin
            sck_reg <= 1'b0;
            st_reg  <= (txbits_reg == 6'h00 && rxbits_reg == 6'h00) ? SFRA_H_TAIL : SFRA_H_LOW;
          end
        end
        SFRA_H_TAIL:
        begin
          if (ph_end)
          begin
            cs_n_reg  <= 1'b1;
            dq_oe_reg <= 4'h0;
            st_reg    <= SFRA_H_GAP;
          end
        end
        default:
        begin
          if (ph_end)
          begin
            busy_o  <= 1'b0;
            done_o  <= 1'b1;
            rdata_o <= rx_reg;
            st_reg  <= SFRA_H_IDLE;
          end
        end
      endcase
    end
  end

  assign link.cs_n    = cs_n_reg;
  assign link.sck     = sck_reg;
  assign link.h_dq    = dq_reg;
  assign link.h_dq_oe = dq_oe_reg;
  assign link.wp_n    = wp_n_reg;
endmodule
`default_nettype wire

// file: tb/sfra_properties.sv
// Purpose: Link checks between host and flash register ends
// Assumes: One clock domain; sees only the shared link
// Notes:   Protocol input is not visible here, so lane sets are broad
`timescale 1ns/10ps
`default_nettype none
module sfra_properties (
  input wire logic       ref_clk_i,
  input wire logic       resetn_i,
  input wire logic       cs_n,
  input wire logic       sck,
  input wire logic       wp_n,
  input wire logic [3:0] h_dq,
  input wire logic [3:0] h_dq_oe,
  input wire logic [3:0] d_dq,
  input wire logic [3:0] d_dq_oe,
  input wire logic [3:0] dq
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!resetn_i);

  sequence frame_open;
    $fell(cs_n);
  endsequence
  sequence frame_close;
    $rose(cs_n);
  endsequence
  sequence deselected_run;
    cs_n [*8];
  endsequence

  AST_SCK_IDLE: assert property (cs_n |-> !sck)
    else $error("serial clock moved while deselected");
  AST_SCK_SETUP: assert property (frame_open |-> !sck [*8])
    else $error("serial clock rose too soon after select");
  AST_CS_GAP: assert property (frame_close |-> deselected_run)
    else $error("select high gap too short");
  AST_DEV_RELEASE: assert property (deselected_run |-> d_dq_oe == 4'h0)
    else $error("device still drives lanes while deselected");
  AST_DEV_OE_SELECTED: assert property ((d_dq_oe != 4'h0) |-> !$past(cs_n, 4))
    else $error("device drove lanes without select");
  AST_NO_CONTENTION: assert property ((h_dq_oe & d_dq_oe) == 4'h0)
    else $error("both ends drive one lane");
  AST_DEV_LANES: assert property (d_dq_oe inside {4'h0, 4'h2, 4'h3, 4'hf})
    else $error("device lane set illegal");
  AST_HOST_LANES: assert property (h_dq_oe inside {4'h0, 4'h1, 4'h3, 4'hf})
    else $error("host lane set illegal");
  AST_DEV_DATA_STEADY: assert property (($rose(sck) && d_dq_oe != 4'h0) |-> ##1 $stable(dq & d_dq_oe) [*6])
    else $error("device data moved while clock high");
  AST_HOST_DATA_STEADY: assert property ($rose(sck) |-> $stable(h_dq & h_dq_oe))
    else $error("host data moved at clock rise");
endmodule
`default_nettype wire

// file: tb/serial_flash_register_access_tb.sv
// Purpose: Host end against flash end, register commands in all protocols
// Assumes: Timed-write counts of 2000 and 3000 cycles, above the package defaults
// Notes:   Expectations come from a small register model kept here
`timescale 1ns/10ps
`default_nettype none
module serial_flash_register_access_tb;
  logic                    ref_clk;
  logic                    resetn;
  logic                    start;
  logic                    wp_n_in;
  logic [7:0]              op;
  logic [15:0]             wdata;
  logic [1:0]              tx_bytes;
  logic [2:0]              rx_bytes;
  sfra_pkg::sfra_proto_type mode;
  logic                    busy;
  logic                    done;
  logic [31:0]             rdata;
  logic [7:0]              sr;
  logic [7:0]              fsr;
  logic [15:0]             nvcr;
  logic [7:0]              vcr;
  logic [7:0]              evcr;
  logic [7:0]              sr_m;
  logic [7:0]              fsr_m;
  logic [15:0]             nv_m;
  logic [7:0]              vcr_m;
  logic [7:0]              evcr_m;
  logic [7:0]              v;
  int                      fail_count;
  int                      checked;

  sfra_if link ();
  sfra_host #(.HALF(16)) u_sfra_host (.ref_clk_i(ref_clk), .resetn_i(resetn), .link(link), .start_i(start),
    .mode_i(mode), .op_i(op), .wdata_i(wdata), .tx_bytes_i(tx_bytes), .rx_bytes_i(rx_bytes), .wp_n_i(wp_n_in),
    .busy_o(busy), .done_o(done), .rdata_o(rdata));
  sfra_device #(.SR_CYC(2000), .NV_CYC(3000)) u_sfra_device (.ref_clk_i(ref_clk), .resetn_i(resetn), .link(link),
    .mode_i(mode), .sr_o(sr), .fsr_o(fsr), .nvcr_o(nvcr), .vcr_o(vcr), .evcr_o(evcr));
  sfra_properties u_sfra_properties (.ref_clk_i(ref_clk), .resetn_i(resetn), .cs_n(link.cs_n), .sck(link.sck),
    .wp_n(link.wp_n), .h_dq(link.h_dq), .h_dq_oe(link.h_dq_oe), .d_dq(link.d_dq), .d_dq_oe(link.d_dq_oe),
    .dq(link.dq));

  always #2.5 ref_clk = ~ref_clk;

  function automatic logic [31:0] rd_exp(input logic [7:0] c, input int n);
    logic [31:0] r;
    logic [7:0]  b;
    r = 32'h0;
    for (int i = 0; i < n; i++)
    begin
      case (c)
        sfra_pkg::OP_RD_SR:   b = sr_m;
        sfra_pkg::OP_RD_FSR:  b = fsr_m;
        sfra_pkg::OP_RD_VCR:  b = vcr_m;
        sfra_pkg::OP_RD_EVCR: b = evcr_m;
        default:              b = (i > 1) ? 8'h00 : 8'((nv_m | sfra_pkg::NVCR_RSVD) >> (8 * i));
      endcase
      r = {r[23:0], b};
    end
    return r;
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask

  task automatic cmd(input logic [7:0] c, input logic [15:0] wd, input logic [1:0] tx, input logic [2:0] rx);
    int n;
    n = 0;
    @(posedge ref_clk);
    #1;
    op = c;
    wdata = wd;
    tx_bytes = tx;
    rx_bytes = rx;
    start = 1'b1;
    @(posedge ref_clk);
    #1;
    start = 1'b0;
    chk("busy_o taken", 32'h1, {31'h0, busy});
    do
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (done !== 1'b1 && n < 5000);
    if (n >= 5000)
      chk("done", 32'h1, 32'h0);
    chk("busy_o released", 32'h0, {31'h0, busy});
  endtask

  task automatic rd(input logic [7:0] c, input int n);
    logic [31:0] m;
    m = (n >= 4) ? 32'hffffffff : ((32'h1 << (8 * n)) - 32'h1);
    cmd(c, 16'h0, 2'h0, 3'(n));
    chk($sformatf("read %h", c), rd_exp(c, n), rdata & m);
  endtask

  task automatic wren();
    cmd(sfra_pkg::OP_WREN, 16'h0, 2'h0, 3'h0);
    sr_m[1] = 1'b1;
  endtask

  task automatic timed_write(input logic [7:0] c, input logic [15:0] w);
    int k;
    k = 0;
    wren();
    cmd(c, w, (c == sfra_pkg::OP_WR_NVCR) ? 2'h2 : 2'h1, 3'h0);
    cmd(sfra_pkg::OP_RD_SR, 16'h0, 2'h0, 3'h1);
    chk("busy bit", 32'h1, {31'h0, rdata[0]});
    cmd(sfra_pkg::OP_RD_FSR, 16'h0, 2'h0, 3'h1);
    chk("ready bit", 32'h0, {31'h0, rdata[7]});
    do
    begin
      cmd(sfra_pkg::OP_RD_SR, 16'h0, 2'h0, 3'h1);
      k++;
    end while (rdata[0] !== 1'b0 && k < 20);
    chk("busy clears", 32'h0, {31'h0, k >= 20});
    sr_m[1:0] = 2'h0;
    if (c == sfra_pkg::OP_WR_NVCR)
      nv_m = w;
    else
      sr_m[7:2] = w[7:2];
    rd(sfra_pkg::OP_RD_SR, 2);
  endtask

  task automatic final_report();
    $display("Checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    ref_clk = 1'b0;
    resetn = 1'b0;
    start = 1'b0;
    wp_n_in = 1'b1;
    op = 8'h0;
    wdata = 16'h0;
    tx_bytes = 2'h0;
    rx_bytes = 3'h0;
    mode = sfra_pkg::SFRA_EXT;
    fail_count = 0;
    checked = 0;
    {sr_m, fsr_m, nv_m} = {sfra_pkg::SR_RESET, sfra_pkg::FSR_RESET, sfra_pkg::NVCR_RESET};
    {vcr_m, evcr_m} = {sfra_pkg::VCR_RESET, sfra_pkg::EVCR_RESET};
    void'($urandom(54));
    repeat (16) @(posedge ref_clk);
    #1;
    resetn = 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    for (int p = 0; p < 3; p++)
    begin
      mode = sfra_pkg::sfra_proto_type'(p);
      rd(sfra_pkg::OP_RD_SR, 1);
      rd(sfra_pkg::OP_RD_FSR, 2);
      rd(sfra_pkg::OP_RD_NVCR, 4);
      rd(sfra_pkg::OP_RD_VCR, 3);
      rd(sfra_pkg::OP_RD_EVCR, 1);
    end
    $display("Test reset reads finished");
    cmd(sfra_pkg::OP_WR_VCR, 16'h00a5, 2'h1, 3'h0);
    rd(sfra_pkg::OP_RD_VCR, 2);
    for (int i = 0; i < 4; i++)
    begin
      mode = sfra_pkg::sfra_proto_type'(2'($urandom_range(2)));
      v = (i == 0) ? 8'h00 : ((i == 3) ? 8'hff : 8'($urandom));
      wren();
      rd(sfra_pkg::OP_RD_SR, 1);
      cmd((i < 2) ? sfra_pkg::OP_WR_VCR : sfra_pkg::OP_WR_EVCR, {8'h00, v}, 2'h1, 3'h0);
      sr_m[1] = 1'b0;
      if (i < 2)
        vcr_m = (v & ~sfra_pkg::VCR_RSVD) | (vcr_m & sfra_pkg::VCR_RSVD);
      else
        evcr_m = (v & ~sfra_pkg::EVCR_RSVD) | (evcr_m & sfra_pkg::EVCR_RSVD);
      rd((i < 2) ? sfra_pkg::OP_RD_VCR : sfra_pkg::OP_RD_EVCR, 3);
    end
    $display("Test volatile writes finished");
    // One byte short of the two-byte write must leave everything alone, the latch still set
    wren();
    cmd(sfra_pkg::OP_WR_NVCR, 16'h1234, 2'h1, 3'h0);
    rd(sfra_pkg::OP_RD_SR, 1);
    rd(sfra_pkg::OP_RD_FSR, 1);
    rd(sfra_pkg::OP_RD_NVCR, 2);
    $display("Test short write finished");
    for (int p = 0; p < 3; p++)
    begin
      mode = sfra_pkg::sfra_proto_type'(p);
      timed_write(sfra_pkg::OP_WR_SR, {8'h00, 8'($urandom) & 8'h7f});
      timed_write(sfra_pkg::OP_WR_NVCR, 16'($urandom));
      rd(sfra_pkg::OP_RD_NVCR, 4);
    end
    $display("Test timed writes finished");
    timed_write(sfra_pkg::OP_WR_SR, 16'h00fc);
    wp_n_in = 1'b0;
    wren();
    cmd(sfra_pkg::OP_WR_SR, 16'h0000, 2'h1, 3'h0);
    fsr_m[1] = 1'b1;
    rd(sfra_pkg::OP_RD_SR, 1);
    rd(sfra_pkg::OP_RD_FSR, 1);
    wp_n_in = 1'b1;
    $display("Test protection finished");
    chk("sr_o", {24'h0, sr_m}, {24'h0, sr});
    chk("fsr_o", {24'h0, fsr_m}, {24'h0, fsr});
    chk("nvcr_o", {16'h0, nv_m | sfra_pkg::NVCR_RSVD}, {16'h0, nvcr});
    chk("vcr_o", {24'h0, vcr_m}, {24'h0, vcr});
    chk("evcr_o", {24'h0, evcr_m}, {24'h0, evcr});
    final_report();
  end

  initial
  begin
    #500000;
    fail_count++;
    final_report();
  end
endmodule
`default_nettype wire
